// File: logic/clock_synth_control.v
`timescale 1ns/10ps
`include "clock_synth_defs.vh"
module clock_synth_control
#(
	parameter CNT_W = 8
)
(
	input wire clk_in,
	input wire reset_in,
	input wire [7:0] index_in,
	input wire [7:0] wdata_in,
	input wire write_in,
	input wire read_in,
	input wire [1:0] clock_select_in,
	input wire [7:0] std_dot_low_in,
	input wire [7:0] std_dot_high_in,
	input wire pin_select_in,
	input wire misc_two_cycle_in,
	input wire test_mem_clk_in,
	input wire test_dot_clk_in,
	output reg [7:0] rdata_out,
	output reg [4:0] mem_n_out,
	output reg [1:0] mem_r_out,
	output reg [6:0] mem_m_out,
	output reg [5:0] dot_n_out,
	output reg [1:0] dot_r_out,
	output reg [7:0] dot_m_out,
	output reg mem_load_out,
	output reg dot_load_out,
	output reg dot_pll_powerdown_out,
	output reg mem_pll_powerdown_out,
	output reg local_bus_enable_oe_out,
	output reg external_mem_clk_select_out,
	output reg external_dot_clk_select_out,
	output reg mem_clk_pin_output_out,
	output reg dot_clk_pin_output_out,
	output reg dot_clk_halve_out,
	output reg dot_clk_invert_out,
	output reg two_cycle_mem_write_out,
	output reg linear_bypass_out
);

////////////////////////////////////////////////////////////////////////
// input synchronisers for the test clocks

wire [1:0] tck_pin;
wire [1:0] tck_rise;

assign tck_pin = {test_mem_clk_in, test_dot_clk_in};

genvar g;

generate
	for (g = 0; g < 2; g = g + 1)
	begin : g_tck
		reg [2:0] stage_r;

		always @(posedge clk_in or posedge reset_in)
		begin
			if (reset_in)
				stage_r <= 3'h0;
			else
				stage_r <= {stage_r[1:0], tck_pin[g]};
		end

		// rising edge taken behind the second flop
		assign tck_rise[g] = stage_r[1] && !stage_r[2];
	end
endgenerate

////////////////////////////////////////////////////////////////////////
// registers

reg [7:0] mem_low_r;
reg [7:0] mem_high_r;
reg [7:0] dot_low_r;
reg [7:0] dot_high_r;
reg [7:0] ctrl_one_r;
reg [7:0] ctrl_two_r;
reg [CNT_W-1:0] test_cnt_r;
reg [CNT_W-1:0] test_cnt_nxt;

function is_idx;
	input [7:0] a;
	input [7:0] b;
	begin
		is_idx = (a == b);
	end
endfunction

wire wr_c1 = write_in && is_idx(index_in, `IDX_CTRL_ONE);
wire wr_c2 = write_in && is_idx(index_in, `IDX_CTRL_TWO);

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
	begin
		mem_low_r <= `MEM_LOW_RESET;
		mem_high_r <= `MEM_HIGH_RESET;
		dot_low_r <= 8'h00;
		dot_high_r <= 8'h00;
		ctrl_one_r <= `CTRL_RESET;
		ctrl_two_r <= `CTRL_RESET;
	end
	else if (write_in)
	begin
		if (is_idx(index_in, `IDX_MEM_LOW))
			mem_low_r <= {1'b0, wdata_in[6:0]};
		else if (is_idx(index_in, `IDX_MEM_HIGH))
			mem_high_r <= {1'b0, wdata_in[6:0]};
		else if (is_idx(index_in, `IDX_DOT_LOW))
			dot_low_r <= wdata_in;
		else if (is_idx(index_in, `IDX_DOT_HIGH))
			dot_high_r <= wdata_in;
		else if (wr_c1)
			ctrl_one_r <= {wdata_in[7:5], 1'b0, wdata_in[3:0]};
		else if (wr_c2)
			ctrl_two_r <= wdata_in;
	end
end

////////////////////////////////////////////////////////////////////////
// test counter, shared by both test clocks

always @*
begin
	test_cnt_nxt = test_cnt_r;
	if (wr_c1 && wdata_in[`C1_CNT_CLR])
		test_cnt_nxt = {CNT_W{1'b0}};
	else if (ctrl_one_r[`C1_CNT_EN])
	begin
		if (ctrl_one_r[`C1_MEM_TEST])
		begin
			if (tck_rise[1])
				test_cnt_nxt = test_cnt_r + 1'b1;
		end
		else if (tck_rise[0])
			test_cnt_nxt = test_cnt_r + 1'b1;
	end
end

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		test_cnt_r <= {CNT_W{1'b0}};
	else
		test_cnt_r <= test_cnt_nxt;
end

////////////////////////////////////////////////////////////////////////
// load sequencing and outputs

wire now_fall = wr_c2 && ctrl_two_r[`C2_NOW_LOAD] &&
	!wdata_in[`C2_NOW_LOAD];
wire now_rise = wr_c2 && !ctrl_two_r[`C2_NOW_LOAD] &&
	wdata_in[`C2_NOW_LOAD];
wire enh_src = (clock_select_in == `CLK_SEL_ENH);
wire [7:0] dot_low_src = enh_src ? dot_low_r : std_dot_low_in;
wire [7:0] dot_high_src = enh_src ? dot_high_r : std_dot_high_in;
wire mem_ld = ctrl_two_r[`C2_MEM_LOAD] || now_rise || now_fall;
wire dot_ld = ctrl_two_r[`C2_DOT_LOAD] || now_rise || now_fall;

reg [7:0] rdata_nxt;

always @*
begin
	if (is_idx(index_in, `IDX_MEM_LOW))
		rdata_nxt = mem_low_r;
	else if (is_idx(index_in, `IDX_MEM_HIGH))
		rdata_nxt = mem_high_r;
	else if (is_idx(index_in, `IDX_DOT_LOW))
		rdata_nxt = dot_low_r;
	else if (is_idx(index_in, `IDX_DOT_HIGH))
		rdata_nxt = dot_high_r;
	else if (is_idx(index_in, `IDX_CTRL_ONE))
		rdata_nxt = ctrl_one_r;
	else if (is_idx(index_in, `IDX_CTRL_TWO))
		rdata_nxt = ctrl_two_r;
	else if (is_idx(index_in, `IDX_TEST_LOW))
		rdata_nxt = test_cnt_r[7:0];
	else
		rdata_nxt = 8'h00;
end

////////////////////////////////////////////////////////////////////////
// read data, valid for the cycle after the read strobe

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		rdata_out <= 8'h00;
	else if (read_in)
		rdata_out <= rdata_nxt;
	else
		rdata_out <= 8'h00;
end

////////////////////////////////////////////////////////////////////////
// load strobes towards the PLLs

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		mem_load_out <= 1'b0;
	else
		mem_load_out <= mem_ld;
end

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		dot_load_out <= 1'b0;
	else
		dot_load_out <= dot_ld;
end

////////////////////////////////////////////////////////////////////////
// memory clock parameters, held between loads

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		mem_n_out <= `MEM_N_RESET;
	else if (mem_ld)
		mem_n_out <= mem_low_r[4:0];
end

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		mem_r_out <= `MEM_R_RESET;
	else if (mem_ld)
		mem_r_out <= mem_low_r[6:5];
end

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		mem_m_out <= `MEM_M_RESET;
	else if (mem_ld)
		mem_m_out <= mem_high_r[6:0];
end

////////////////////////////////////////////////////////////////////////
// dot clock parameters from the selected source

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		dot_n_out <= 6'h00;
	else if (dot_ld)
		dot_n_out <= dot_low_src[5:0];
end

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		dot_r_out <= 2'h0;
	else if (dot_ld)
		dot_r_out <= dot_low_src[7:6];
end

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		dot_m_out <= 8'h00;
	else if (dot_ld)
		dot_m_out <= dot_high_src;
end

////////////////////////////////////////////////////////////////////////
// control one outputs

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		dot_pll_powerdown_out <= 1'b0;
	else
		dot_pll_powerdown_out <= ctrl_one_r[`C1_DOT_PD];
end

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		mem_pll_powerdown_out <= 1'b0;
	else
		mem_pll_powerdown_out <= ctrl_one_r[`C1_MEM_PD];
end

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		local_bus_enable_oe_out <= 1'b1;
	else
		local_bus_enable_oe_out <= !ctrl_one_r[`C1_LBE_TRI];
end

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		external_mem_clk_select_out <= 1'b0;
	else
		external_mem_clk_select_out <= ctrl_one_r[`C1_EXT_MEM];
end

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		external_dot_clk_select_out <= 1'b0;
	else
		external_dot_clk_select_out <= ctrl_one_r[`C1_EXT_DOT];
end

////////////////////////////////////////////////////////////////////////
// control two outputs

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		mem_clk_pin_output_out <= 1'b0;
	else
		mem_clk_pin_output_out <= ctrl_two_r[`C2_MEM_OUT] &&
			pin_select_in;
end

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		dot_clk_pin_output_out <= 1'b0;
	else
		dot_clk_pin_output_out <= ctrl_two_r[`C2_DOT_OUT];
end

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		dot_clk_halve_out <= 1'b0;
	else
		dot_clk_halve_out <= ctrl_two_r[`C2_HALVE];
end

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		dot_clk_invert_out <= 1'b0;
	else
		dot_clk_invert_out <= ctrl_two_r[`C2_INVERT];
end

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		two_cycle_mem_write_out <= 1'b0;
	else
		two_cycle_mem_write_out <= ctrl_two_r[`C2_TWO_CYC];
end

always @(posedge clk_in or posedge reset_in)
begin
	if (reset_in)
		linear_bypass_out <= 1'b0;
	else
		linear_bypass_out <= ctrl_two_r[`C2_TWO_CYC] &&
			misc_two_cycle_in;
end

endmodule

// File: logic/clock_synth_defs.vh
`ifndef CLOCK_SYNTH_DEFS_VH
`define CLOCK_SYNTH_DEFS_VH
// register indices behind the sequencer data port
`define IDX_MEM_LOW 8'h10
`define IDX_MEM_HIGH 8'h11
`define IDX_DOT_LOW 8'h12
`define IDX_DOT_HIGH 8'h13
`define IDX_CTRL_ONE 8'h14
`define IDX_CTRL_TWO 8'h15
`define IDX_TEST_HIGH 8'h16
`define IDX_TEST_LOW 8'h17
// power-on parameter values for a 45 MHz memory clock
`define MEM_LOW_RESET 8'h4A
`define MEM_HIGH_RESET 8'h2C
// the same power-on values split into the loaded fields
`define MEM_N_RESET 5'h0A
`define MEM_R_RESET 2'h2
`define MEM_M_RESET 7'h2C
`define CTRL_RESET 8'h00
// control one fields
`define C1_DOT_PD 0
`define C1_MEM_PD 1
`define C1_CNT_EN 2
`define C1_MEM_TEST 3
`define C1_CNT_CLR 4
`define C1_LBE_TRI 5
`define C1_EXT_MEM 6
`define C1_EXT_DOT 7
// control two fields
`define C2_MEM_LOAD 0
`define C2_DOT_LOAD 1
`define C2_MEM_OUT 2
`define C2_DOT_OUT 3
`define C2_HALVE 4
`define C2_NOW_LOAD 5
`define C2_INVERT 6
`define C2_TWO_CYC 7
// clock-select code choosing the enhanced pair
`define CLK_SEL_ENH 2'h3
`endif

// File: testbench/clock_synth_control_assertions.sv
`timescale 1ns/10ps
module clock_synth_checker (
	input wire clk_in,
	input wire reset_in,
	input wire [7:0] index_in,
	input wire [7:0] wdata_in,
	input wire write_in,
	input wire dot_pll_powerdown_out,
	input wire mem_pll_powerdown_out,
	input wire local_bus_enable_oe_out,
	input wire external_mem_clk_select_out,
	input wire dot_clk_pin_output_out,
	input wire dot_clk_halve_out,
	input wire dot_clk_invert_out,
	input wire two_cycle_mem_write_out
);
	reg [7:0] wd1;
	reg [7:0] wd2;
	wire w14 = write_in && index_in == 8'h14;
	wire w15 = write_in && index_in == 8'h15;
	always @(posedge clk_in)
		{wd2, wd1} <= {wd1, wdata_in};
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	a_dot_pd:
		assert property (w14 |-> ##2 dot_pll_powerdown_out == wd2[0])
		else $error("dot pd wrong");
	a_mem_pd:
		assert property (w14 |-> ##2 mem_pll_powerdown_out == wd2[1])
		else $error("mem pd wrong");
	a_lbe_tri:
		assert property (w14 |-> ##2 local_bus_enable_oe_out != wd2[5])
		else $error("oe wrong");
	a_ext_mem:
		assert property (w14 |-> ##2 external_mem_clk_select_out == wd2[6])
		else $error("ext mem wrong");
	a_dot_pin:
		assert property (w15 |-> ##2 dot_clk_pin_output_out == wd2[3])
		else $error("dot pin wrong");
	a_halve_bit:
		assert property (w15 |-> ##2 dot_clk_halve_out == wd2[4])
		else $error("halve wrong");
	a_invert_bit:
		assert property (w15 |-> ##2 dot_clk_invert_out == wd2[6])
		else $error("invert wrong");
	a_two_cycle:
		assert property (w15 |-> ##2 two_cycle_mem_write_out == wd2[7])
		else $error("two cycle wrong");
endmodule
bind clock_synth_control clock_synth_checker u_chk (.*);

// File: testbench/clock_synth_control_test.sv
`timescale 1ns/10ps
`include "clock_synth_defs.vh"
module clock_synth_control_test;
	reg clk_in = 0, reset_in = 1, write_in = 0, read_in = 0;
	reg [7:0] index_in = 8'h00, wdata_in = 8'h00;
	reg [7:0] std_dot_low_in = 8'h41, std_dot_high_in = 8'h33;
	reg [1:0] clock_select_in = 2'h0;
	reg pin_select_in = 0, misc_two_cycle_in = 0;
	reg test_mem_clk_in = 0, test_dot_clk_in = 0;
	wire [7:0] rdata_out, dot_m_out;
	wire [4:0] mem_n_out;
	wire [1:0] mem_r_out, dot_r_out;
	wire [6:0] mem_m_out;
	wire [5:0] dot_n_out;
	wire mem_load_out, dot_load_out, dot_pll_powerdown_out;
	wire mem_pll_powerdown_out, local_bus_enable_oe_out;
	wire external_mem_clk_select_out, external_dot_clk_select_out;
	wire mem_clk_pin_output_out, dot_clk_pin_output_out;
	wire dot_clk_halve_out, dot_clk_invert_out;
	wire two_cycle_mem_write_out, linear_bypass_out;
	integer fail_count = 0, num_checks = 0, i;
	clock_synth_control u_dut (.*);
	initial forever #5 clk_in = ~clk_in;
	task chk(input [7:0] seen, input [7:0] exp);
	begin
		num_checks = num_checks + 1;
		if (seen !== exp)
		begin
			fail_count = fail_count + 1;
			$display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
		end
	end
	endtask
	task wr(input [7:0] idx, input [7:0] d);
	begin
		@(negedge clk_in);
		{index_in, wdata_in, write_in} = {idx, d, 1'b1};
		@(negedge clk_in);
		write_in = 0;
	end
	endtask
	task rd(input [7:0] idx, input [7:0] exp);
	begin
		@(negedge clk_in);
		{index_in, read_in} = {idx, 1'b1};
		@(negedge clk_in);
		read_in = 0;
		chk(rdata_out, exp);
	end
	endtask
	task tick(input [1:0] m);
	begin
		repeat (4) @(negedge clk_in);
		{test_mem_clk_in, test_dot_clk_in} = m;
		repeat (4) @(negedge clk_in);
		{test_mem_clk_in, test_dot_clk_in} = 2'b00;
	end
	endtask
	task report_and_stop;
	begin
		$display("checks %0d failures %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	initial
	begin
		#200000;
		fail_count = fail_count + 1;
		report_and_stop;
	end
	initial
	begin
		repeat (20) @(negedge clk_in);
		reset_in = 0;
		rd(8'h10, `MEM_LOW_RESET);
		rd(8'h11, `MEM_HIGH_RESET);
		chk({1'b0, mem_r_out, mem_n_out}, `MEM_LOW_RESET);
		for (i = 4; i < 8; i = i + 1)
			rd(8'h10 + i, 8'h00);
		rd(8'h20, 8'h00);
		$display("reset test done");
		wr(8'h10, 8'hFF);
		wr(8'h11, 8'hFF);
		rd(8'h10, 8'h7F);
		rd(8'h11, 8'h7F);
		wr(8'h15, 8'h01);
		repeat (2) @(negedge clk_in);
		chk({1'b0, mem_r_out, mem_n_out}, 8'h7F);
		chk({mem_load_out, mem_m_out}, 8'hFF);
		wr(8'h15, 8'h00);
		clock_select_in = `CLK_SEL_ENH;
		wr(8'h12, 8'hC5);
		wr(8'h13, 8'h81);
		wr(8'h15, 8'h02);
		repeat (2) @(negedge clk_in);
		chk({dot_r_out, dot_n_out}, 8'hC5);
		chk({dot_load_out, dot_m_out[6:0]}, 8'h81);
		chk(dot_m_out, 8'h81);
		wr(8'h15, 8'h00);
		clock_select_in = 2'h0;
		wr(8'h11, 8'h05);
		wr(8'h15, 8'h20);
		chk({mem_load_out, mem_m_out}, 8'h85);
		wr(8'h15, 8'h00);
		repeat (2) @(negedge clk_in);
		chk({dot_r_out, dot_n_out}, 8'h41);
		chk(dot_m_out ^ mem_m_out, 8'h36);
		$display("load test done");
		{pin_select_in, misc_two_cycle_in} = 2'b11;
		wr(8'h14, 8'hE3);
		repeat (2) @(negedge clk_in);
		chk({external_dot_clk_select_out, local_bus_enable_oe_out,
			mem_pll_powerdown_out}, 8'h05);
		rd(8'h14, 8'hE3);
		wr(8'h15, 8'hDC);
		repeat (2) @(negedge clk_in);
		chk({linear_bypass_out, mem_clk_pin_output_out}, 8'h03);
		rd(8'h15, 8'hDC);
		wr(8'h15, 8'h00);
		$display("control test done");
		wr(8'h14, 8'h04);
		repeat (5) tick(2'b01);
		rd(8'h17, 8'h05);
		wr(8'h14, 8'h1C);
		repeat (3) tick(2'b01);
		tick(2'b10);
		rd(8'h17, 8'h01);
		wr(8'h14, 8'h08);
		tick(2'b10);
		wr(8'h16, 8'hFF);
		wr(8'h17, 8'hFF);
		rd(8'h16, 8'h00);
		rd(8'h17, 8'h01);
		$display("counter test done");
		report_and_stop;
	end
endmodule
